// [design/spi_err_regs.svh]
// field positions, codes and reset values for the spi error responder
`ifndef SPI_ERR_REGS_SVH
`define SPI_ERR_REGS_SVH
`define CMD_MSB         31
`define CMD_LSB         28
`define CMD_SENSOR_BIT  3
`define CMD_WRITE_BIT   2
`define ADDR_MSB        23
`define ADDR_LSB        16
`define WDATA_MSB       15
`define WDATA_LSB       8
`define CRC_MSB         7
`define BASIC_ERR       2'b11
`define SF_SPI_ERR      2'b11
`define SD_ERR_UNSIGNED 12'h000
`define SD_ERR_SIGNED   12'h800
`define FRAME_BITS      8'h20
`define LOCK_WR_ADDR    8'h14
`define CRC_POLY        8'h1d
`define CRC_SEED        8'hff
`define TX_RESET        32'h0000_0000
`endif

// [design/spi_err_pkg.sv]
// types shared by the spi error responder
package spi_err_pkg;
  typedef enum logic {KIND_REG, KIND_SENSOR} resp_kind_e;
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic [2:0] source_identifier;
  } request_s;
  typedef struct packed {
    logic [7:0]  count;
    logic [31:0] word;
    logic        mismatch;
  } snapshot_s;
endpackage : spi_err_pkg

// [design/spi_error_response_logic.sv]
// spi slave frame checker and error response builder
`timescale 1ns/1ps
`include "spi_err_regs.svh"
module spi_error_response_logic #(
  parameter logic [7:0] CRC_POLY = `CRC_POLY,
  parameter logic [7:0] CRC_SEED = `CRC_SEED
) (
  input  wire logic                       clock,
  input  wire logic                       rst_n,
  input  wire logic                       sclk,
  input  wire logic                       ss_n,
  input  wire logic                       mosi,
  input  wire logic                       miso_fb,
  output logic                            miso_o,
  output logic                            miso_oe,
  input  wire logic [7:0]                 source_enable,
  input  wire logic                       init_done_lock,
  input  wire logic                       signed_format,
  input  wire logic                       sensor_no_data,
  input  wire logic                       dev_error,
  input  wire logic [1:0]                 dev_sf,
  input  wire logic [23:0]                normal_resp,
  input  wire logic                       status_three_clear,
  output logic                            device_status_three_miso_err,
  output logic                            reg_wr_req,
  output logic                            reg_rd_req,
  output logic                            sensor_req,
  output spi_err_pkg::request_s           req
);

  // checksum shared by command check and all responses
  function automatic logic [7:0] crc8(input logic [23:0] d);
    logic [7:0] c;
    c = CRC_SEED;
    for (int i = 23; i >= 0; i--) begin
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? CRC_POLY : 8'h00);
    end
    return c;
  endfunction : crc8

  // ---------------- link side, clocked by sclk ----------------
  logic [7:0]  count;
  logic [31:0] rx;
  logic        mismatch;
  logic [31:0] tx_word;
  wire  logic  link_clr = ss_n | ~rst_n;
  wire  logic  in_frame = (count < `FRAME_BITS);
  wire  logic  intended = in_frame ? tx_word[5'd31 - count[4:0]] : 1'b0;

  // drive the bit under the counter while selected
  assign miso_o  = intended;
  assign miso_oe = ~ss_n;

  // edge counter, mosi shifter, miso readback check
  always_ff @(posedge sclk or posedge link_clr) begin
    if (link_clr) begin
      count    <= 8'h00;
      rx       <= 32'h0000_0000;
      mismatch <= 1'b0;
    end else begin
      if (count != 8'hff) count <= count + 8'h01;
      rx <= {rx[30:0], mosi};
      if (in_frame && (miso_fb != intended)) mismatch <= 1'b1;
    end
  end

  // snapshot at select release, before the counter clears
  spi_err_pkg::snapshot_s snap;
  always_ff @(posedge ss_n or negedge rst_n) begin
    if (!rst_n) snap <= '0;
    else        snap <= '{count: count, word: rx, mismatch: mismatch};
  end

  // ---------------- core side, clocked by clock ----------------
  logic ss_q1, ss_q2, ss_q3, sc_q1, sc_q2;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      {ss_q1, ss_q2, ss_q3} <= 3'b111;
      {sc_q1, sc_q2}        <= 2'b00;
    end else begin
      {ss_q1, ss_q2, ss_q3} <= {ss_n, ss_q1, ss_q2};
      {sc_q1, sc_q2}        <= {sclk, sc_q1};
    end
  end
  wire logic sel_fall = ss_q3 & ~ss_q2;
  wire logic sel_rise = ~ss_q3 & ss_q2;

  // frame decode from the snapshot
  wire logic [3:0] cmd       = snap.word[`CMD_MSB:`CMD_LSB];
  wire logic       is_sensor = cmd[`CMD_SENSOR_BIT];
  wire logic       is_write  = ~is_sensor & cmd[`CMD_WRITE_BIT];
  wire logic       is_read   = ~is_sensor & ~cmd[`CMD_WRITE_BIT];
  wire logic [7:0] addr      = snap.word[`ADDR_MSB:`ADDR_LSB];
  wire logic       no_edges  = (snap.count == 8'h00);
  wire logic       bad_count = ~no_edges & (snap.count != `FRAME_BITS);
  wire logic       bad_crc   = crc8(snap.word[31:8]) != snap.word[`CRC_MSB:0];
  wire logic       bad_src   = is_sensor & ~source_enable[cmd[2:0]];
  wire logic       bad_lock  = is_write & init_done_lock & (addr != `LOCK_WR_ADDR);
  logic            start_err;
  wire logic       stop_err  = sc_q2;
  wire logic       frame_bad = start_err | stop_err | bad_count
                             | (~no_edges & (bad_crc | bad_src | bad_lock));
  wire logic       valid     = ~no_edges & ~frame_bad;
  wire logic       mis       = ~no_edges & snap.mismatch;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n)        start_err <= 1'b0;
    else if (sel_fall) start_err <= sc_q2;
    else if (sel_rise) start_err <= 1'b0;
  end

  // error state latched at each frame end, except a select with no edges and no clock error
  logic                    err_pend;
  logic                    int_pend;
  logic [1:0]              sf_snap;
  logic [3:0]              last_cmd;
  spi_err_pkg::resp_kind_e kind;
  logic                    build;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      err_pend <= 1'b0;
      int_pend <= 1'b0;
      sf_snap  <= 2'b00;
      last_cmd <= 4'h0;
      kind     <= spi_err_pkg::KIND_REG;
      build    <= 1'b0;
    end else begin
      build <= sel_rise;
      if (sel_rise && !(no_edges && !start_err && !stop_err)) begin
        // latch at release, report next frame
        // spi error selects the error frame
        err_pend <= frame_bad | mis;
        int_pend <= dev_error;
        sf_snap  <= dev_sf;
        last_cmd <= cmd;
        kind     <= is_sensor ? spi_err_pkg::KIND_SENSOR : spi_err_pkg::KIND_REG;
      end
    end
  end

  // requests to the device core
  // sensor ignored on mismatch
  wire logic go = sel_rise & valid;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      reg_wr_req <= 1'b0;
      reg_rd_req <= 1'b0;
      sensor_req <= 1'b0;
      req        <= '0;
    end else begin
      reg_wr_req <= go & is_write;
      reg_rd_req <= go & is_read & ~mis;
      sensor_req <= go & is_sensor & ~mis;
      if (go) req <= '{addr: addr, wdata: snap.word[`WDATA_MSB:`WDATA_LSB],
                       source_identifier: cmd[2:0]};
    end
  end

  // sticky mismatch flag, a set beats a clear
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n)                  device_status_three_miso_err <= 1'b0;
    else if (sel_rise && mis)    device_status_three_miso_err <= 1'b1;
    else if (status_three_clear) device_status_three_miso_err <= 1'b0;
  end

  // response field selection
  wire logic [1:0]  sf_out = err_pend ? `SF_SPI_ERR : sf_snap;
  wire logic [11:0] sd_err = signed_format ? `SD_ERR_SIGNED : `SD_ERR_UNSIGNED;
  // echo only for internal errors, order C0,C3,C2,C1
  wire logic [3:0]  echo   = err_pend ? 4'h0 : {last_cmd[0], last_cmd[3:1]};
  // register error frame, no sensor data
  wire logic [23:0] up_reg = {4'h0, `BASIC_ERR, 2'b00, 16'h0000};
  // sensor error frame with data field
  wire logic [23:0] up_sd  = {echo, `BASIC_ERR, sd_err, 4'h0, sf_out};
  wire logic [23:0] up_nd  = {4'h0, `BASIC_ERR, 16'h0000, sf_out};
  wire logic        use_err = err_pend | int_pend;
  wire logic [23:0] up_sel = !use_err                           ? normal_resp
                           : (kind == spi_err_pkg::KIND_REG)   ? up_reg
                           : sensor_no_data                     ? up_nd
                           : up_sd;

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n)     tx_word <= `TX_RESET;
    else if (build) tx_word <= {up_sel, crc8(up_sel)};
  end

endmodule : spi_error_response_logic

// [bench/spi_error_response_sva.sv]
// port assertions for the spi error responder
`timescale 1ns/1ps
module spi_error_response_sva (
  input wire logic                  clock,
  input wire logic                  rst_n,
  input wire logic                  ss_n,
  input wire logic                  miso_oe,
  input wire logic                  status_three_clear,
  input wire logic                  device_status_three_miso_err,
  input wire logic                  reg_wr_req,
  input wire logic                  reg_rd_req,
  input wire logic                  sensor_req,
  input wire spi_err_pkg::request_s req
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  wire logic any_req = reg_wr_req | reg_rd_req | sensor_req;
  wire logic flag = device_status_three_miso_err;
  // port relations
  pad_drive_a: assert property (miso_oe == !ss_n) else $error("miso enable off select");
  one_request_a: assert property ($onehot0({reg_wr_req, reg_rd_req, sensor_req}))
    else $error("two requests at once");
  req_pulse_a: assert property (any_req |=> !any_req) else $error("request too long");
  after_frame_a: assert property (any_req |-> ss_n && $past(ss_n, 3))
    else $error("request inside frame");
  req_hold_a: assert property (!ss_n |=> $stable(req)) else $error("req moved in frame");
  flag_hold_a: assert property (flag && !status_three_clear |=> flag)
    else $error("flag lost");
  flag_set_a: assert property ($rose(flag) |-> ss_n) else $error("flag set in frame");
  flag_clear_a: assert property ($fell(flag) |-> $past(status_three_clear))
    else $error("flag dropped uncleared");
  cover property (reg_wr_req && flag);
  cover property (sensor_req);
  cover property ($fell(flag));
endmodule : spi_error_response_sva
bind spi_error_response_logic spi_error_response_sva u_sva (.clock(clock), .rst_n(rst_n),
  .ss_n(ss_n), .miso_oe(miso_oe), .status_three_clear(status_three_clear),
  .device_status_three_miso_err(device_status_three_miso_err), .reg_wr_req(reg_wr_req),
  .reg_rd_req(reg_rd_req), .sensor_req(sensor_req), .req(req));

// [bench/spi_host_model.sv]
// spi host model: select, link clock, command bits, pad readback
`timescale 1ns/1ps
module spi_host_model (
  output logic      sclk,
  output logic      ss_n,
  output logic      mosi,
  output logic      miso_fb,
  input  wire logic miso_o,
  input  wire logic miso_oe
);
  logic        flip = 1'b0;
  logic [31:0] rx = 32'h0;
  initial {sclk, ss_n, mosi} = 3'b010;
  // pad echo, inverted on a commanded fault
  always_comb miso_fb = miso_oe ? miso_o ^ flip : ~mosi;
  // clock at level hi at select, low before the first edge, n edges
  task automatic frame(input logic [31:0] w, input int n, input bit hi, input bit f);
    sclk = hi;
    #40 ss_n = 1'b0;
    // a high clock is held long enough for the core synchroniser to see it
    #(hi ? 250 : 20) sclk = 1'b0;
    flip = f;
    for (int i = 0; i < n; i++) begin
      mosi = w[31 - (i % 32)];
      #40 rx = {rx[30:0], miso_o};
      sclk = 1'b1;
      #40 sclk = 1'b0;
    end
    #40 ss_n = 1'b1;
    flip = 1'b0;
    mosi = ~mosi;
  endtask : frame
endmodule : spi_host_model

// [bench/tb.sv]
// self-checking bench for the spi error responder
`timescale 1ns/1ps
`include "spi_err_regs.svh"
module tb;
  logic                  clock = 1'b0, rst_n = 1'b0;
  logic                  sclk, ss_n, mosi, miso_fb, miso_o, miso_oe, flag, wr, rd, sen;
  logic [7:0]            source_enable = 8'h0f;
  logic                  init_done_lock = 1'b0, signed_format = 1'b0, sensor_no_data = 1'b0;
  logic                  status_three_clear = 1'b0, dev_error = 1'b0;
  logic [1:0]            dev_sf = 2'b00;
  logic [23:0]           normal_resp = 24'h0;
  logic [2:0]            seen = 3'b000;
  logic [31:0]           pend = 32'h0, r;
  spi_err_pkg::request_s req;
  int                    num_errors = 0, comparisons = 0, seed = 32'h28aae3d6;
  always #50 clock = ~clock;
  always @(posedge clock) seen <= seen | {wr, rd, sen};
  spi_host_model host (.sclk(sclk), .ss_n(ss_n), .mosi(mosi), .miso_fb(miso_fb),
    .miso_o(miso_o), .miso_oe(miso_oe));
  spi_error_response_logic DUT (.clock(clock), .rst_n(rst_n), .sclk(sclk), .ss_n(ss_n),
    .mosi(mosi), .miso_fb(miso_fb), .miso_o(miso_o), .miso_oe(miso_oe),
    .source_enable(source_enable), .init_done_lock(init_done_lock),
    .signed_format(signed_format), .sensor_no_data(sensor_no_data), .dev_error(dev_error),
    .dev_sf(dev_sf), .normal_resp(normal_resp), .status_three_clear(status_three_clear),
    .device_status_three_miso_err(flag), .reg_wr_req(wr), .reg_rd_req(rd),
    .sensor_req(sen), .req(req));
  // frame word with crc byte
  function automatic logic [31:0] word(input logic [23:0] d);
    logic [7:0] c;
    c = `CRC_SEED;
    for (int i = 23; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? `CRC_POLY : 8'h00);
    return {d, c};
  endfunction : word
  function automatic logic [31:0] cmd(input logic [3:0] c, input logic [7:0] a, d);
    return word({c, 4'h0, a, d});
  endfunction : cmd
  // expected error frame, register or sensor kind
  function automatic logic [23:0] errw(input bit s);
    logic [11:0] sd;
    sd = sensor_no_data ? 12'h000 : signed_format ? `SD_ERR_SIGNED : `SD_ERR_UNSIGNED;
    return s ? {4'h0, `BASIC_ERR, sd, 4'h0, `SF_SPI_ERR} : {4'h0, `BASIC_ERR, 18'h0};
  endfunction : errw
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : check
  // one frame: check the response it shifts out (32-edge frames only) and the request pulses it caused
  task automatic run(input logic [31:0] w, input int n, input bit hi, input bit f,
                     input logic [2:0] e, input logic [31:0] nx);
    seen = 3'b000;
    host.frame(w, n, hi, f);
    if (n == 32)
      check(host.rx, pend);
    pend = nx;
    repeat (8) @(negedge clock);
    check({29'h0, seen}, {29'h0, e});
  endtask : run
  task automatic tally_and_finish();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : tally_and_finish
  // reset, random traffic, then corner frames
  initial begin
    repeat (6) @(negedge clock);
    rst_n = 1'b1;
    repeat (4) @(negedge clock);
    for (int k = 0; k < 16; k++) begin
      r = $random(seed);
      normal_resp = r[31:8];
      {sensor_no_data, signed_format} = r[5:4];
      if (r[3] && r[2:0] > 3'd3)
        run(cmd(r[3:0], r[15:8], r[23:16]), 32, 0, 0, 3'b000, word(errw(1'b1)));
      else
        run(cmd(r[3:0], r[15:8], r[23:16]), 32, 0, 0,
            {~r[3] & r[2], ~r[3] & ~r[2], r[3]}, word(normal_resp));
      if (!r[3] || r[2:0] < 3'd4)
        check({13'h0, req}, {13'h0, r[15:8], r[23:16], r[2:0]});
    end
    r = cmd(4'h0, 8'h10, 8'h00);
    run(r, 31, 0, 0, 3'b000, word(errw(1'b0)));
    run(r, 33, 0, 0, 3'b000, word(errw(1'b0)));
    run(r, 32, 1, 0, 3'b000, word(errw(1'b0)));
    run(r ^ 32'h1, 32, 0, 0, 3'b000, word(errw(1'b0)));
    run(r, 0, 0, 0, 3'b000, pend);
    init_done_lock = 1'b1;
    run(cmd(4'h4, 8'h22, 8'h5a), 32, 0, 0, 3'b000, word(errw(1'b0)));
    run(cmd(4'h4, `LOCK_WR_ADDR, 8'h5a), 32, 0, 0, 3'b100, word(normal_resp));
    init_done_lock = 1'b0;
    run(cmd(4'h4, 8'h22, 8'ha5), 32, 0, 1, 3'b100, word(errw(1'b0)));
    check({31'h0, flag}, 32'h1);
    run(r, 32, 0, 1, 3'b000, word(errw(1'b0)));
    run(cmd(4'h9, 8'h00, 8'h00), 32, 0, 1, 3'b000, word(errw(1'b1)));
    status_three_clear = 1'b1;
    @(negedge clock);
    status_three_clear = 1'b0;
    @(negedge clock);
    check({31'h0, flag}, 32'h0);
    run(r, 32, 0, 0, 3'b010, word(normal_resp));
    // internal error: echo C0,C3,C2,C1 of source 1 request, captured detailed status
    {dev_error, dev_sf, sensor_no_data, signed_format} = 5'b1_01_01;
    run(cmd(4'h9, 8'h00, 8'h00), 32, 0, 0, 3'b001,
        word({4'b1100, `BASIC_ERR, `SD_ERR_SIGNED, 4'h0, 2'b01}));
    {dev_error, dev_sf} = 3'b0_00;
    run(r, 32, 0, 0, 3'b010, word(normal_resp));
    tally_and_finish();
  end
  // watchdog against a hung frame
  initial begin
    #1000000;
    num_errors++;
    tally_and_finish();
  end
endmodule : tb
